/* design/serial_adc_control.sv */
/*
  Control and serial interface of an eight-channel SAR converter: start
  bit hunt, control byte capture, track/hold timing, channel mux select,
  result framing with strobe, and power-mode decode.
  Assumes the serial pins come from another domain and are resampled on
  clk, which must run many times faster than the serial clock; the
  comparator verdict is an analog level and is resampled too.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_adc_control #(
  parameter int STEPS = adc_ctrl_pkg::SAR_STEPS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic conversion_strobe_out,
  output logic strobe_oe,
  // Analog front end
  input wire logic comparator_high,
  output logic [STEPS-1:0] dac_code,
  output logic track_enable,
  output logic [2:0] pos_channel,
  output logic [2:0] neg_channel,
  output logic neg_to_common_ref,
  // Mode status
  output logic polarity_select,
  output logic input_config_select,
  output logic [adc_ctrl_pkg::PD_W-1:0] power_mode,
  output logic full_power_down,
  output logic fast_power_down,
  output logic reduced_power,
  output logic converting
);
  import adc_ctrl_pkg::*;

  logic [2:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] din_sync;
  logic [1:0] comp_sync;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_low;
  logic din_s;
  logic comp_s;
  cap_state_t cap_state;
  logic [3:0] bit_cnt;
  logic [CTRL_BITS-1:0] shift_reg;
  conv_state_t conv_state;
  logic [4:0] conv_cnt;
  logic [4:0] conv_cnt_next;
  logic start_ok;
  logic track_evt;
  logic hold_evt;
  logic conv_end;
  logic sar_step;
  logic sar_busy;
  logic [2:0] sel_reg;
  logic [2:0] acq_cnt;
  logic oe_reg;

  // Channel mux decode: {common, negative, positive}
  function automatic logic [6:0] chan_map(input logic [2:0] sel,
                                          input logic single);
    logic [2:0] pos;
    pos = {sel[1:0], sel[2]};
    if (single) begin
      chan_map = {1'b1, pos, pos};
    end else begin
      chan_map = {1'b0, pos ^ 3'h1, pos};
    end
  endfunction : chan_map

  //////////////////////////////////////////////////////////////////////////
  // Resample the pins; logic reads the second stage, and the serial clock's third stage for edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_sync <= 3'h0;
      cs_sync <= 2'h3;
      din_sync <= 2'h0;
      comp_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      cs_sync <= {cs_sync[0], cs_n};
      din_sync <= {din_sync[0], din};
      comp_sync <= {comp_sync[0], comparator_high};
    end
  end

  // Serial clock edges and settled pin levels
  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  assign cs_low = ~cs_sync[1];
  assign din_s = din_sync[1];
  assign comp_s = comp_sync[1];

  //////////////////////////////////////////////////////////////////////////
  // Events derived from the capture and conversion state
  assign conv_cnt_next = conv_cnt + 5'h01;
  // A new start bit is accepted once the running result is far enough out
  assign start_ok = (conv_state == CV_IDLE) ||
                    (conv_cnt >= CNT_START_OK);
  assign track_evt = sclk_fall && cs_low && cap_state == CAP_SHIFT &&
                     bit_cnt == BITS_TRACK;
  // Only a completed control byte ever starts a conversion
  assign hold_evt = sclk_fall && cs_low && cap_state == CAP_WAIT;
  assign sar_step = conv_state == CV_RUN && sclk_rise &&
                    conv_cnt_next >= CNT_FIRST &&
                    conv_cnt_next <= CNT_LAST;
  assign conv_end = conv_state == CV_RUN && sclk_rise &&
                    conv_cnt_next == CNT_DONE;

  //////////////////////////////////////////////////////////////////////////
  // Start bit hunt and control byte shift
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cap_state <= CAP_HUNT;
      bit_cnt <= 4'h0;
      shift_reg <= '0;
    end else if (!cs_low) begin
      cap_state <= CAP_HUNT;
      bit_cnt <= 4'h0;
    end else begin
      case (cap_state)
        CAP_HUNT: begin
          // Zeros before the start bit leave no trace
          if (sclk_rise && din_s && start_ok) begin
            shift_reg <= {shift_reg[CTRL_BITS-2:0], din_s};
            bit_cnt <= 4'h1;
            cap_state <= CAP_SHIFT;
          end
        end
        CAP_SHIFT: begin
          if (sclk_rise) begin
            shift_reg <= {shift_reg[CTRL_BITS-2:0], din_s};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == BITS_LAST) begin
              cap_state <= CAP_WAIT;
            end
          end
        end
        CAP_WAIT: begin
          if (sclk_fall) begin
            cap_state <= CAP_HUNT;
          end
        end
        default: begin
          cap_state <= CAP_HUNT;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Selections: channel early at track start, the rest at hold
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_reg <= SEL_RESET;
      polarity_select <= 1'b1;
      input_config_select <= 1'b1;
      power_mode <= PD_NORMAL;
    end else if (hold_evt) begin
      sel_reg <= shift_reg[SEL_HI:SEL_LO];
      polarity_select <= shift_reg[POL_BIT];
      input_config_select <= shift_reg[CFG_BIT];
      power_mode <= shift_reg[PD_HI:PD_LO];
    end else if (track_evt) begin
      sel_reg <= shift_reg[EARLY_SEL_HI:EARLY_SEL_LO];
    end
  end

  // Mux select lines toward the analog front end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pos_channel <= 3'h0;
      neg_channel <= 3'h0;
      neg_to_common_ref <= 1'b1;
    end else begin
      {neg_to_common_ref, neg_channel, pos_channel} <=
        chan_map(sel_reg, input_config_select);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Track/hold switch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      track_enable <= 1'b1;
    end else if (hold_evt) begin
      track_enable <= 1'b0;
    end else if (track_evt || conv_end) begin
      track_enable <= 1'b1;
    end
  end

  // Serial clock rises seen during acquisition, for checking only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acq_cnt <= 3'h0;
    end else if (track_evt) begin
      acq_cnt <= 3'h0;
    end else if (sclk_rise && cap_state != CAP_HUNT && acq_cnt != 3'h7) begin
      acq_cnt <= acq_cnt + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequence, strobe and result framing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conv_state <= CV_IDLE;
      conv_cnt <= 5'h00;
      conversion_strobe_out <= 1'b0;
      dout <= 1'b0;
    end else if (hold_evt) begin
      conv_state <= CV_RUN;
      conv_cnt <= 5'h00;
      conversion_strobe_out <= 1'b0;
      dout <= 1'b0;
    end else if (conv_state == CV_RUN && sclk_rise) begin
      conv_cnt <= conv_cnt_next;
      conversion_strobe_out <= conv_cnt_next == CNT_STROBE;
      if (sar_step) begin
        // Bipolar flips the MSB to give two's complement
        dout <= comp_s ^ (conv_cnt_next == CNT_FIRST &&
                          !polarity_select);
      end else begin
        dout <= 1'b0;
      end
      if (conv_end) begin
        conv_state <= CV_IDLE;
      end
    end
  end

  // Pin drivers follow chip select
  always_ff @(posedge clk) begin
    if (!resetn) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= cs_low;
    end
  end

  assign dout_oe = oe_reg;
  assign strobe_oe = oe_reg;

  //////////////////////////////////////////////////////////////////////////
  // Power-down only between conversions; serial access wakes the part
  always_ff @(posedge clk) begin
    if (!resetn) begin
      full_power_down <= 1'b0;
      fast_power_down <= 1'b0;
      reduced_power <= 1'b0;
      converting <= 1'b0;
    end else begin
      full_power_down <= power_mode == PD_FULL && conv_state == CV_IDLE &&
                         cap_state == CAP_HUNT;
      fast_power_down <= power_mode == PD_FAST && conv_state == CV_IDLE &&
                         cap_state == CAP_HUNT;
      reduced_power <= power_mode == PD_REDUCED;
      converting <= conv_state == CV_RUN;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // SAR register
  sar_engine #(
    .STEPS(STEPS)
  ) u_sar (
    .clk(clk),
    .resetn(resetn),
    .start(hold_evt),
    .step(sar_step),
    .keep(comp_s),
    .dac_code(dac_code),
    .busy(sar_busy)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_hold_edge;
    hold_evt;
  endsequence

  sequence s_held_running;
    !track_enable && conv_state == CV_RUN && sar_busy;
  endsequence

  property p_shift_in;
    (cs_low && cap_state == CAP_SHIFT && sclk_rise) |=>
      shift_reg[0] == $past(din_s);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("data input not captured on serial clock rise");

  property p_zero_skip;
    (cs_low && cap_state == CAP_HUNT && sclk_rise && !din_s) |=>
      cap_state == CAP_HUNT;
  endproperty
  a_zero_skip: assert property (p_zero_skip)
    else $error("leading zero left the start bit hunt");

  property p_track;
    track_evt |=> track_enable ##1 acq_cnt == 3'h0;
  endproperty
  a_track: assert property (p_track)
    else $error("tracking did not start after fifth bit");

  property p_hold;
    s_hold_edge |=> s_held_running ##1 conv_cnt == 5'h00;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold did not start conversion");

  property p_acq;
    hold_evt |-> acq_cnt == ACQ_CYCLES;
  endproperty
  a_acq: assert property (p_acq)
    else $error("acquisition window not three serial clocks");

  property p_single;
    input_config_select |=> neg_to_common_ref;
  endproperty
  a_single: assert property (p_single)
    else $error("single-ended negative not on common ref");

  property p_pair;
    (!input_config_select && sel_reg[2] && $stable(sel_reg)) |=>
      pos_channel[0] && neg_channel == {pos_channel[2:1], 1'b0};
  endproperty
  a_pair: assert property (p_pair)
    else $error("differential pair polarity wrong");

  property p_reconnect;
    conv_end |=> track_enable && conv_state == CV_IDLE;
  endproperty
  a_reconnect: assert property (p_reconnect)
    else $error("positive input not reconnected at end");

  property p_all_ones;
    (hold_evt && shift_reg == CTRL_ALL_ONES) |=> ##1
      pos_channel == 3'h7 && neg_to_common_ref && polarity_select &&
      power_mode == PD_NORMAL && !full_power_down && !fast_power_down;
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("all-ones byte decoded wrongly");

  property p_strobe_place;
    $rose(conversion_strobe_out) |-> conv_cnt == CNT_STROBE;
  endproperty
  a_strobe_place: assert property (p_strobe_place)
    else $error("strobe not just before the MSB");

  property p_strobe_len;
    (conversion_strobe_out && sclk_rise) |=>
      !conversion_strobe_out && conv_cnt == CNT_FIRST;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe longer than one serial clock");

  property p_lead_zero;
    (conv_state == CV_RUN && conv_cnt < CNT_FIRST) |-> !dout;
  endproperty
  a_lead_zero: assert property (p_lead_zero)
    else $error("leading result bits not zero");

  property p_float;
    !cs_low |=> !dout_oe && !strobe_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("outputs driven while chip select high");

endmodule : serial_adc_control

`default_nettype wire

/* design/adc_ctrl_pkg.sv */
/*
  Shared constants and types for the serial converter control block:
  control byte layout, reset values, conversion step counts and states.
  Assumes nothing of its surroundings.
*/
package adc_ctrl_pkg;

  // Control byte layout
  localparam int CTRL_BITS = 8;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 4;
  localparam int POL_BIT = 3;
  localparam int CFG_BIT = 2;
  localparam int PD_HI = 1;
  localparam int PD_LO = 0;
  // Select bits sit here once five bits are in
  localparam int EARLY_SEL_HI = 3;
  localparam int EARLY_SEL_LO = 1;
  localparam logic [7:0] CTRL_ALL_ONES = 8'hFF;

  // Bit counts on the serial clock
  localparam logic [3:0] BITS_TRACK = 4'h5;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [2:0] ACQ_CYCLES = 3'h3;
  localparam int SAR_STEPS = 12;

  // Rising edges counted from the hold edge
  localparam logic [4:0] CNT_STROBE = 5'h02;
  localparam logic [4:0] CNT_FIRST = 5'h03;
  localparam logic [4:0] CNT_LAST = 5'h0E;
  localparam logic [4:0] CNT_DONE = 5'h0F;
  localparam logic [4:0] CNT_START_OK = 5'h08;

  // Power modes
  localparam int PD_W = 2;
  localparam logic [1:0] PD_FULL = 2'h0;
  localparam logic [1:0] PD_FAST = 2'h1;
  localparam logic [1:0] PD_REDUCED = 2'h2;
  localparam logic [1:0] PD_NORMAL = 2'h3;

  // Reset values of the stored selections
  localparam logic [2:0] SEL_RESET = 3'h0;

  typedef enum logic [1:0] {
    CAP_HUNT = 2'b00,
    CAP_SHIFT = 2'b01,
    CAP_WAIT = 2'b10
  } cap_state_t;

  typedef enum logic {
    CV_IDLE = 1'b0,
    CV_RUN = 1'b1
  } conv_state_t;

endpackage : adc_ctrl_pkg

/* design/sar_engine.sv */
/*
  Successive-approximation register: sets one trial bit per step, keeps
  or drops it on the comparator verdict, walks from MSB to the last step.
  Assumes start and step are single-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_engine #(
  parameter int STEPS = adc_ctrl_pkg::SAR_STEPS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic step,
  input wire logic keep,
  // Trial code and status
  output logic [STEPS-1:0] dac_code,
  output logic busy
);
  import adc_ctrl_pkg::*;

  localparam logic [STEPS-1:0] MSB_ONLY = {1'b1, {(STEPS-1){1'b0}}};
  localparam logic [$clog2(STEPS)-1:0] IDX_TOP = STEPS[$clog2(STEPS)-1:0] - 1'b1;

  logic [$clog2(STEPS)-1:0] idx_reg;

  //////////////////////////////////////////////////////////////////////////
  // Bit decisions on the held sample
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dac_code <= '0;
      idx_reg <= '0;
      busy <= 1'b0;
    end else if (start) begin
      dac_code <= MSB_ONLY;
      idx_reg <= IDX_TOP;
      busy <= 1'b1;
    end else if (step && busy) begin
      if (!keep) begin
        dac_code[idx_reg] <= 1'b0;
      end
      if (idx_reg != '0) begin
        dac_code[idx_reg - 1'b1] <= 1'b1;
        idx_reg <= idx_reg - 1'b1;
      end else begin
        busy <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sar_start;
    @(posedge clk) disable iff (!resetn)
    start |=> busy && dac_code == MSB_ONLY;
  endproperty
  a_sar_start: assert property (p_sar_start)
    else $error("SAR did not load its first trial bit");

  property p_sar_end;
    @(posedge clk) disable iff (!resetn)
    (step && busy && idx_reg == '0 && !start) |=> !busy;
  endproperty
  a_sar_end: assert property (p_sar_end)
    else $error("SAR still busy after its last step");

endmodule : sar_engine

`default_nettype wire

/* verification/spi_host_model.sv */
/*
  Host model for the serial converter: a serial master that frames each
  transfer with chip select, shifts bits out MSB first and samples the
  data pin on every serial clock rise.
  Assumes the bench's system clock; pins change on its falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  // System clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  // Half serial period in clk cycles: 160 ns period, 6.25 MHz
  localparam int HALF = 16;

  logic dout_pin;

  //////////////////////////////////////////////////////////////////////////
  // Pin level seen by the host: floating when the device lets go
  assign dout_pin = dout_oe ? dout : 1'bz;

  // Idle: select high, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // One framed full-duplex transfer of n bits
  task automatic xfer(input logic [47:0] bits, input int n,
                      output logic [47:0] rx);
    rx = '0;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      repeat (HALF) @(negedge clk);
      rx = {rx[46:0], dout_pin};
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    din = ~din; // Line no longer carries data
  endtask : xfer

endmodule : spi_host_model
`default_nettype wire

/* verification/serial_adc_control_tb.sv */
/*
  Self-checking bench for the serial converter control block: a table
  of single conversions, then reset, leading zeros, back-to-back and
  aborted frames. The comparator is an ideal model of a fixed sample.
  Assumes the host model and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_adc_control_tb;
  import adc_ctrl_pkg::*;

  localparam int LIMIT = 40000;

  typedef struct packed {
    logic [7:0] cfg;
    logic [11:0] s;
    logic [2:0] pos;
    logic [2:0] neg;
  } row_t;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cs_n, sclk, din, dout, dout_oe, conversion_strobe_out, strobe_oe;
  logic comparator_high, track_enable, neg_to_common_ref;
  logic polarity_select, input_config_select, converting;
  logic full_power_down, fast_power_down, reduced_power;
  logic [SAR_STEPS-1:0] dac_code;
  logic [2:0] pos_channel, neg_channel;
  logic [PD_W-1:0] power_mode;
  logic [11:0] sample_val = 12'h000;
  logic [47:0] rx_v, strb_v, trk_v;
  logic saw_conv = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Control bytes with the channel each should pick
  row_t rows [16] = '{
    '{8'h8F, 12'h000, 3'h0, 3'h0}, '{8'h9E, 12'hFFF, 3'h2, 3'h0},
    '{8'hAD, 12'h800, 3'h4, 3'h0}, '{8'hBC, 12'h7FF, 3'h6, 3'h0},
    '{8'hC7, 12'h001, 3'h1, 3'h0}, '{8'hDF, 12'hA5A, 3'h3, 3'h0},
    '{8'hEF, 12'h5A5, 3'h5, 3'h0}, '{8'hFF, 12'h3C7, 3'h7, 3'h0},
    '{8'h8B, 12'h123, 3'h0, 3'h1}, '{8'h93, 12'hC3C, 3'h2, 3'h3},
    '{8'hAB, 12'h999, 3'h4, 3'h5}, '{8'hB3, 12'h666, 3'h6, 3'h7},
    '{8'hCB, 12'h0F0, 3'h1, 3'h0}, '{8'hD3, 12'hF0F, 3'h3, 3'h2},
    '{8'hEB, 12'h400, 3'h5, 3'h4}, '{8'hF3, 12'hBFF, 3'h7, 3'h6}
  };

  //////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Ideal comparator: sample at or above the trial code
  assign comparator_high = (sample_val >= dac_code);

  serial_adc_control i_dut (
    .clk(clk), .resetn(resetn),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .conversion_strobe_out(conversion_strobe_out), .strobe_oe(strobe_oe),
    .comparator_high(comparator_high), .dac_code(dac_code),
    .track_enable(track_enable), .pos_channel(pos_channel),
    .neg_channel(neg_channel), .neg_to_common_ref(neg_to_common_ref),
    .polarity_select(polarity_select),
    .input_config_select(input_config_select), .power_mode(power_mode),
    .full_power_down(full_power_down), .fast_power_down(fast_power_down),
    .reduced_power(reduced_power), .converting(converting)
  );

  spi_host_model i_host (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe)
  );

  //////////////////////////////////////////////////////////////////////////
  // Strobe and track state seen at each serial clock rise
  always @(posedge sclk) begin
    strb_v = {strb_v[46:0], conversion_strobe_out};
    trk_v = {trk_v[46:0], track_enable};
  end

  // Notes any conversion activity
  always @(negedge clk) begin
    if (converting === 1'b1) saw_conv = 1'b1;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result bytes: three zeros, twelve bits, one zero
  function automatic logic [15:0] exp_res(input logic [11:0] s,
                                          input logic uni);
    logic [11:0] c;
    c = s;
    if (!uni) c[11] = ~c[11];
    return {3'b000, c, 1'b0};
  endfunction : exp_res

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic frame(input logic [47:0] bits, input int n,
                       input logic [11:0] s);
    sample_val = s;
    strb_v = '0;
    trk_v = '0;
    i_host.xfer(bits, n, rx_v);
    repeat (4) @(negedge clk);
  endtask : frame

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      logic [1:0] pm;
      pm = rows[i].cfg[1:0];
      frame({24'h0, rows[i].cfg, 16'h0}, 24, rows[i].s);
      chk(48'(rx_v[15:0]), 48'(exp_res(rows[i].s, rows[i].cfg[3])));
      chk(48'(strb_v[23:0]), 48'h002000);
      chk(48'(trk_v[23:0]), 48'hFF0001);
      chk(48'(pos_channel), 48'(rows[i].pos));
      chk(48'(neg_to_common_ref), 48'(rows[i].cfg[2]));
      if (rows[i].cfg[2] == 1'b0)
        chk(48'(neg_channel), 48'(rows[i].neg));
      chk(48'({polarity_select, input_config_select, power_mode}),
          48'(rows[i].cfg[3:0]));
      chk(48'({full_power_down, fast_power_down, reduced_power}),
          48'({pm == PD_FULL, pm == PD_FAST, pm == PD_REDUCED}));
      chk(48'({dout_oe, strobe_oe}), 48'h0);
    end
    $display("test table done");

    // Reset in mid-run restores the idle selections
    resetn = 1'b0;
    repeat (5) @(negedge clk);
    chk(48'({dout_oe, strobe_oe, conversion_strobe_out, track_enable,
             neg_to_common_ref, polarity_select, input_config_select,
             power_mode, full_power_down, fast_power_down, reduced_power,
             converting, pos_channel, neg_channel, dac_code}),
        48'({13'b0001111110000, 18'h0}));
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    $display("test reset done");

    // Leading zeros before the start bit are skipped
    frame({21'h0, 3'b000, 8'hAD, 16'h0}, 27, 12'h5A5);
    chk(48'(rx_v[15:0]), 48'(exp_res(12'h5A5, 1'b1)));
    chk(48'(strb_v[26:0]), 48'h002000);
    $display("test leading zeros done");

    // Second byte rides on the first result: 16 clocks per conversion
    frame({8'h0, 8'hFF, 8'h00, 8'h93, 16'h0}, 40, 12'h3C7);
    chk(48'(rx_v[31:0]), {16'h0, exp_res(12'h3C7, 1'b1),
                          exp_res(12'h3C7, 1'b0)});
    chk(48'(strb_v[39:0]), 48'h0020002000);
    chk(48'({pos_channel, neg_channel}), 48'h13);
    $display("test back to back done");

    // Cut byte and an all-zero frame start nothing
    saw_conv = 1'b0;
    frame(48'h16, 5, 12'hFFF);
    frame(48'h0, 24, 12'hFFF);
    chk(48'({saw_conv, track_enable, dout_oe, strobe_oe}), 48'h4);
    frame({24'h0, 8'hFF, 16'h0}, 24, 12'hFFF);
    chk(48'(rx_v[15:0]), 48'(exp_res(12'hFFF, 1'b1)));
    $display("test abort done");
    end_sim();
  end

endmodule : serial_adc_control_tb
`default_nettype wire
